// ### verilog/event_log_store.sv
// Purpose: Event log store with clearing policies and an Avalon-MM slave
// Assumes: One clock, inputs synchronous to clk_sys
// Notes:   Order and age come from insertion, not from timestamps
`timescale 1ns/1ps
`include "event_log_params.svh"

// Overview of operation
// - Fill-and-stop refuses entries when log full
// - Full log reusable only after clear command
// - FIFO full: drop N oldest, then store
// - FIFO count N configurable, count or percent
// - Above M, Nth oldest aged out clears N
// - Below M entries never removed by age
// - Age, N, M configurable; N, M percent
// - Age and order follow insertion sequence
// - Latest policy write selects active policy; writes of code 3 are ignored
// - One receiver and one log per terminus
// - Internal virtual events written straight in
// - Store, stamp, report capacity, read, clear
// - Entry: kind byte, length byte, payload
// - Three kinds select payload layout
// - UTC offset half hours, 0xFF unspecified
// - Forty-bit epoch seconds in bytes 1-5
// - Hundredths byte, legal zero to 99
// - Whole-second stamps write hundredths 0xFF
// - Event payload follows the stamp bytes
// - Receiver endpoint id held for termini
module event_log_store (
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  input  wire logic                        ce,
  input  wire logic [7:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic                        ev_valid,
  input  wire event_log_pkg::event_in_type ev_data,
  output logic                             ev_ready,
  input  wire logic                        virt_valid,
  input  wire event_log_pkg::event_in_type virt_data,
  output logic                             virt_ready,
  input  wire event_log_pkg::stamp_type    stamp,
  output logic                             log_full,
  output logic      [7:0]                  receiver_eid
);

  localparam int CAP = `EVLOG_CAPACITY;
  localparam int CW  = `EVLOG_CNT_W;
  localparam int PW  = `EVLOG_PTR_W;

  // ************************************************************
  // State
  // ************************************************************
  event_log_pkg::policy_type policy_reg;
  event_log_pkg::policy_type policy_next;
  logic [7:0]                n_reg;
  logic [7:0]                m_reg;
  logic                      n_pct_reg;
  logic                      m_pct_reg;
  logic [31:0]               age_reg;
  logic [PW-1:0]             rd_index_reg;
  logic [7:0]                receiver_reg;
  logic [PW-1:0]             head_reg;
  logic [PW-1:0]             head_next;
  logic [CW-1:0]             count_reg;
  logic [CW-1:0]             count_next;
  logic [31:0]               tick_reg;
  logic                      ev_ready_reg;
  logic                      virt_ready_reg;
  logic                      turn_reg;
  logic                      waitreq_reg;
  logic [31:0]               readdata_reg;
  logic [31:0]               rdata_next;
  logic                      full_reg;
  event_log_pkg::entry_type  mem [CAP];
  event_log_pkg::entry_type  new_entry;
  event_log_pkg::entry_type  rd_entry;
  event_log_pkg::event_in_type in_data;
  logic [PW-1:0]             wr_ptr;
  logic [PW-1:0]             age_idx;
  logic [CW-1:0]             n_eff;
  logic [CW-1:0]             m_eff;
  logic                      bus_take;
  logic                      wr;
  logic                      wr_ctrl;
  logic                      clear_cmd;
  logic                      policy_wr;
  logic                      take_ev;
  logic                      take_virt;
  logic                      take;
  logic                      age_old;
  logic                      age_fire;
  logic                      fifo_drop;
  logic                      space_next;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [CW-1:0] to_count(input logic [7:0] v, input logic pct);
    logic [15:0] prod;
    logic [15:0] cnt;
    prod = 16'(v) * 16'(CAP);
    cnt  = pct ? prod / `EVLOG_PERCENT_FULL : 16'(v);
    if (cnt > 16'(CAP)) begin
      cnt = 16'(CAP);
    end
    if (cnt == 16'h0000) begin
      cnt = 16'h0001;
    end
    return cnt[CW-1:0];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ************************************************************
  // Bus decode
  // ************************************************************
  assign bus_take  = ce && (avs_read || avs_write) && waitreq_reg;
  assign wr        = bus_take && avs_write;
  assign wr_ctrl   = wr && (avs_address == `EVLOG_OFF_CTRL);
  assign clear_cmd = wr_ctrl && avs_byteenable[1] && avs_writedata[`EVLOG_CTRL_CLEAR_BIT];
  assign policy_wr = wr_ctrl && avs_byteenable[0] && (avs_writedata[1:0] != `EVLOG_POLICY_BAD);

  always_comb begin
    policy_next = policy_reg;
    if (policy_wr) begin
      policy_next = event_log_pkg::policy_type'(avs_writedata[1:0]);
    end
  end

  // ************************************************************
  // Clearing decisions
  // ************************************************************
  assign n_eff     = to_count(n_reg, n_pct_reg);
  assign m_eff     = to_count(m_reg, m_pct_reg);
  assign take_ev   = ce && ev_valid && ev_ready_reg;
  assign take_virt = ce && virt_valid && virt_ready_reg;
  assign take      = take_ev || take_virt;
  assign in_data   = take_virt ? virt_data : ev_data;
  assign age_idx   = head_reg + n_eff[PW-1:0] - {{(PW-1){1'b0}}, 1'b1};
  assign age_old   = (tick_reg - mem[age_idx].insert_tick) > age_reg;
  assign age_fire  = ce && !clear_cmd && (policy_reg == event_log_pkg::POLICY_CLEAR_ON_AGE)
                     && (count_reg > m_eff) && (count_reg >= n_eff) && age_old;
  assign fifo_drop = take && (policy_reg == event_log_pkg::POLICY_FIFO)
                     && (count_reg == CW'(CAP));

  always_comb begin
    head_next  = head_reg;
    count_next = count_reg;
    if (clear_cmd) begin
      count_next = '0;
    end else if (age_fire || fifo_drop) begin
      head_next  = head_reg + n_eff[PW-1:0];
      count_next = count_reg - n_eff;
    end
    wr_ptr = head_next + count_next[PW-1:0];
    if (take) begin
      count_next = count_next + 1'b1;
    end
    space_next = (policy_next == event_log_pkg::POLICY_FIFO)
                 || (count_next < CW'(CAP));
  end

  // ************************************************************
  // Entry build
  // ************************************************************
  always_comb begin
    new_entry               = '0;
    new_entry.event_payload = in_data.event_payload;
    new_entry.insert_tick   = tick_reg;
    case (in_data.entry_kind)
      `EVLOG_KIND_PLATFORM, `EVLOG_KIND_VENDOR_TS: begin
        new_entry.entry_kind            = in_data.entry_kind;
        new_entry.entry_payload_length  = `EVLOG_STAMP_BYTES + 8'(in_data.payload_bytes);
        new_entry.utc_offset_half_hours = stamp.offset_valid ? stamp.utc_offset_half_hours
                                                             : `EVLOG_UNSPECIFIED;
        new_entry.epoch_seconds         = stamp.epoch_seconds;
        new_entry.hundredths_of_second  =
          (stamp.fine_valid && stamp.hundredths_of_second <= `EVLOG_HUNDREDTHS_MAX)
          ? stamp.hundredths_of_second : `EVLOG_UNSPECIFIED;
      end
      default: begin
        new_entry.entry_kind           = `EVLOG_KIND_VENDOR;
        new_entry.entry_payload_length = 8'(in_data.payload_bytes);
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (ce && take) begin
      mem[wr_ptr] <= new_entry;
    end
  end

  // ************************************************************
  // Log pointers and intake
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      head_reg  <= '0;
      count_reg <= '0;
      full_reg  <= 1'b0;
    end else if (ce) begin
      head_reg  <= head_next;
      count_reg <= count_next;
      full_reg  <= (count_next == CW'(CAP));
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ev_ready_reg   <= 1'b0;
      virt_ready_reg <= 1'b0;
      turn_reg       <= 1'b0;
    end else if (ce) begin
      turn_reg       <= !turn_reg;
      ev_ready_reg   <= space_next && turn_reg;
      virt_ready_reg <= space_next && !turn_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_reg <= '0;
    end else if (ce) begin
      tick_reg <= tick_reg + 32'h0000_0001;
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      policy_reg <= event_log_pkg::POLICY_FILL_STOP;
    end else if (ce) begin
      policy_reg <= policy_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      n_reg     <= `EVLOG_N_RESET;
      m_reg     <= `EVLOG_M_RESET;
      n_pct_reg <= 1'b0;
      m_pct_reg <= 1'b0;
    end else if (wr && avs_address == `EVLOG_OFF_PARAM) begin
      if (avs_byteenable[0]) begin
        n_reg <= avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        m_reg <= avs_writedata[`EVLOG_PARAM_M_LSB +: 8];
      end
      if (avs_byteenable[2]) begin
        n_pct_reg <= avs_writedata[`EVLOG_PARAM_N_PCT_BIT];
        m_pct_reg <= avs_writedata[`EVLOG_PARAM_M_PCT_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      age_reg <= `EVLOG_AGE_RESET;
    end else if (wr && avs_address == `EVLOG_OFF_AGE) begin
      age_reg <= merge(age_reg, avs_writedata, avs_byteenable);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_index_reg <= '0;
      receiver_reg <= `EVLOG_RECEIVER_RESET;
    end else if (wr && avs_byteenable[0]) begin
      if (avs_address == `EVLOG_OFF_RD_INDEX) begin
        rd_index_reg <= avs_writedata[PW-1:0];
      end
      if (avs_address == `EVLOG_OFF_RECEIVER) begin
        receiver_reg <= avs_writedata[7:0];
      end
    end
  end

  // ************************************************************
  // Read mux and bus answer
  // ************************************************************
  assign rd_entry = mem[head_reg + rd_index_reg];

  always_comb begin
    rdata_next = '0;
    case (avs_address)
      `EVLOG_OFF_CTRL:     rdata_next = {30'h0, policy_reg};
      `EVLOG_OFF_PARAM:    rdata_next = {14'h0, m_pct_reg, n_pct_reg, m_reg, n_reg};
      `EVLOG_OFF_AGE:      rdata_next = age_reg;
      `EVLOG_OFF_STATUS: begin
        rdata_next[CW-1:0] = count_reg;
        rdata_next[`EVLOG_STATUS_CAP_LSB +: 8] = 8'(CAP);
        rdata_next[`EVLOG_STATUS_FULL_BIT] = full_reg;
        rdata_next[`EVLOG_STATUS_POL_LSB +: 2] = policy_reg;
      end
      `EVLOG_OFF_RD_INDEX: rdata_next = {28'h0, rd_index_reg};
      `EVLOG_OFF_RD_HDR: begin
        if (rd_index_reg < count_reg[PW-1:0] || count_reg == CW'(CAP)) begin
          rdata_next = {rd_entry.hundredths_of_second, rd_entry.utc_offset_half_hours,
                        rd_entry.entry_payload_length, rd_entry.entry_kind};
        end
      end
      `EVLOG_OFF_RD_SEC_LO: rdata_next = rd_entry.epoch_seconds[31:0];
      `EVLOG_OFF_RD_SEC_HI: rdata_next = {24'h0, rd_entry.epoch_seconds[39:32]};
      `EVLOG_OFF_RD_DATA:   rdata_next = rd_entry.event_payload;
      `EVLOG_OFF_RECEIVER:  rdata_next = {24'h0, receiver_reg};
      default:              rdata_next = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      waitreq_reg  <= 1'b1;
      readdata_reg <= '0;
    end else if (ce) begin
      if (bus_take) begin
        waitreq_reg  <= 1'b0;
        readdata_reg <= avs_read ? rdata_next : 32'h0;
      end else begin
        waitreq_reg <= 1'b1;
      end
    end
  end

  assign avs_readdata    = readdata_reg;
  assign avs_waitrequest = waitreq_reg;
  assign ev_ready        = ev_ready_reg;
  assign virt_ready      = virt_ready_reg;
  assign log_full        = full_reg;
  assign receiver_eid    = receiver_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  fill_stop_refuse_a:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (policy_reg == event_log_pkg::POLICY_FILL_STOP && count_reg == CW'(CAP))
    |-> !ev_ready_reg && !virt_ready_reg)
  else $error("full fill-and-stop log still offers intake");

  clear_empties_a:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    clear_cmd |=> count_reg <= CW'(1))
  else $error("clear command did not empty the log");

  fifo_drop_a:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fifo_drop && !clear_cmd) |=> count_reg == CW'(CAP) - $past(n_eff) + CW'(1))
  else $error("full fifo intake left wrong count");

  age_purge_a:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (age_fire && !take) |=> count_reg == $past(count_reg) - $past(n_eff)
                            && head_reg == $past(head_reg) + $past(n_eff[PW-1:0]))
  else $error("aged purge removed wrong entries");

  age_retain_a:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ce && policy_reg == event_log_pkg::POLICY_CLEAR_ON_AGE && count_reg < m_eff
     && !clear_cmd) |=> count_reg >= $past(count_reg))
  else $error("entries lost below threshold");

  policy_select_a:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    policy_wr |=> policy_reg == $past(avs_writedata[1:0]))
  else $error("policy write not applied");

  coarse_stamp_a:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (take && !stamp.fine_valid && new_entry.entry_kind != `EVLOG_KIND_VENDOR)
    |=> mem[$past(wr_ptr)].hundredths_of_second == `EVLOG_UNSPECIFIED)
  else $error("coarse stamp did not mark hundredths unspecified");

  pct_floor_a:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    n_eff != '0 && m_eff != '0 && n_eff <= CW'(CAP))
  else $error("effective count outside one to capacity");

  bus_answer_a:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus_take |=> !avs_waitrequest ##1 (avs_waitrequest || !ce))
  else $error("bus answer not one cycle long");

endmodule // event_log_store

// ### verilog/event_log_params.svh
// Purpose: Constants for the event log store: map, fields, resets, sizes
// Assumes: Included by bare name where needed
// Notes:   Definitions only
`ifndef EVENT_LOG_PARAMS_SVH
`define EVENT_LOG_PARAMS_SVH

// ************************************************************
// Sizes
// ************************************************************
`define EVLOG_CAPACITY      16
`define EVLOG_CNT_W         5
`define EVLOG_PTR_W         4
`define EVLOG_PERCENT_FULL  16'h0064

// ************************************************************
// Register byte offsets
// ************************************************************
`define EVLOG_OFF_CTRL      8'h00
`define EVLOG_OFF_PARAM     8'h04
`define EVLOG_OFF_AGE       8'h08
`define EVLOG_OFF_STATUS    8'h0c
`define EVLOG_OFF_RD_INDEX  8'h10
`define EVLOG_OFF_RD_HDR    8'h14
`define EVLOG_OFF_RD_SEC_LO 8'h18
`define EVLOG_OFF_RD_SEC_HI 8'h1c
`define EVLOG_OFF_RD_DATA   8'h20
`define EVLOG_OFF_RECEIVER  8'h24

// ************************************************************
// Field positions
// ************************************************************
`define EVLOG_CTRL_CLEAR_BIT   8
`define EVLOG_PARAM_M_LSB      8
`define EVLOG_PARAM_N_PCT_BIT  16
`define EVLOG_PARAM_M_PCT_BIT  17
`define EVLOG_STATUS_CAP_LSB   8
`define EVLOG_STATUS_FULL_BIT  16
`define EVLOG_STATUS_POL_LSB   17

// ************************************************************
// Reset values and codes
// ************************************************************
`define EVLOG_N_RESET        8'h04
`define EVLOG_M_RESET        8'h08
`define EVLOG_AGE_RESET      32'h0000_ffff
`define EVLOG_RECEIVER_RESET 8'h00
`define EVLOG_KIND_PLATFORM  8'h00
`define EVLOG_KIND_VENDOR_TS 8'h01
`define EVLOG_KIND_VENDOR    8'h02
`define EVLOG_UNSPECIFIED    8'hff
`define EVLOG_HUNDREDTHS_MAX 8'h63
`define EVLOG_STAMP_BYTES    8'h07
`define EVLOG_POLICY_BAD     2'h3

`endif

// ### verilog/event_log_pkg.sv
// Purpose: Types for the event log store
// Assumes: Nothing
// Notes:   Widths match event_log_params.svh
package event_log_pkg;

  typedef enum logic [1:0] {
    POLICY_FILL_STOP,
    POLICY_FIFO,
    POLICY_CLEAR_ON_AGE
  } policy_type;

  typedef struct packed {
    logic [7:0]  entry_kind;
    logic [2:0]  payload_bytes;
    logic [31:0] event_payload;
  } event_in_type;

  typedef struct packed {
    logic        offset_valid;
    logic [7:0]  utc_offset_half_hours;
    logic [39:0] epoch_seconds;
    logic        fine_valid;
    logic [7:0]  hundredths_of_second;
  } stamp_type;

  typedef struct packed {
    logic [7:0]  entry_kind;
    logic [7:0]  entry_payload_length;
    logic [7:0]  utc_offset_half_hours;
    logic [39:0] epoch_seconds;
    logic [7:0]  hundredths_of_second;
    logic [31:0] event_payload;
    logic [31:0] insert_tick;
  } entry_type;

endpackage

// ### testbench/event_source.sv
// Purpose: Reporting terminus model that offers events to the log
// Assumes: send is called just after a rising edge of clk_sys
// Notes:   Released data lines show the inverse of the last value
`timescale 1ns/1ps
module event_source (
  input  wire logic                   clk_sys,
  input  wire logic                   ev_ready,
  output logic                        ev_valid,
  output event_log_pkg::event_in_type ev_data
);
  initial begin
    ev_valid = 1'b0;
    ev_data  = '0;
  end
  // ********
  // Offer held until taken
  // ********
  task automatic send(input event_log_pkg::event_in_type d);
    @(posedge clk_sys);
    ev_valid <= 1'b1;
    ev_data  <= d;
    do @(posedge clk_sys); while (ev_ready !== 1'b1);
    ev_valid <= 1'b0;
    ev_data  <= ~d;
  endtask
endmodule // event_source

// ### testbench/event_log_store_with_clearing_bench.sv
// Purpose: Self-checking bench for the event log store
// Assumes: Bus answer follows the designer's one-cycle contract
// Notes:   Reset values first, then entry format rows and policy cases
`timescale 1ns/1ps
`include "event_log_params.svh"
module event_log_store_with_clearing_bench;
  typedef struct packed {
    logic [7:0]  kind;
    logic        fine;
    logic        offv;
    logic [7:0]  hund;
    logic [31:0] hdr;
    logic [31:0] mask;
  } row_type;
  logic                        clk_sys;
  logic                        rst_n;
  logic                        ce;
  logic [7:0]                  avs_address;
  logic                        avs_read;
  logic                        avs_write;
  logic [31:0]                 avs_writedata;
  logic [31:0]                 avs_readdata;
  logic                        avs_waitrequest;
  logic                        ev_valid;
  event_log_pkg::event_in_type ev_data;
  logic                        ev_ready;
  logic                        virt_valid;
  event_log_pkg::event_in_type virt_data;
  logic                        virt_ready;
  event_log_pkg::stamp_type    stamp;
  logic                        log_full;
  logic [7:0]                  receiver_eid;
  logic [31:0]                 rdata;
  int                          error_cnt;
  int                          checks_done;
  int                          cycles;
  row_type                     rows [5];

  event_log_store i_event_log_store (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ev_valid(ev_valid), .ev_data(ev_data), .ev_ready(ev_ready), .virt_valid(virt_valid),
    .virt_data(virt_data), .virt_ready(virt_ready), .stamp(stamp), .log_full(log_full),
    .receiver_eid(receiver_eid));

  event_source i_event_source (
    .clk_sys(clk_sys), .ev_ready(ev_ready), .ev_valid(ev_valid), .ev_data(ev_data));

  // ********
  // Helpers
  // ********
  task automatic tally_and_finish;
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(rdata, exp);
  endtask

  function automatic event_log_pkg::event_in_type mk(input int k);
    return {8'h00, 3'h4, 32'hc0de_0000 + 32'(k)};
  endfunction

  task automatic fill(input int n, input int base);
    for (int i = 0; i < n; i++) i_event_source.send(mk(base + i));
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ********
  // Main sequence
  // ********
  initial begin
    rst_n = 1'b0; avs_address = 8'h00; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = 32'h0000_0000; virt_valid = 1'b0; virt_data = '0; stamp = '0;
    ce = 1'b1;
    rows = '{'{8'h02, 1'b1, 1'b1, 8'h2a, 32'h0000_0402, 32'h0000_ffff},
             '{8'h07, 1'b1, 1'b1, 8'h2a, 32'h0000_0402, 32'h0000_ffff},
             '{8'h01, 1'b0, 1'b0, 8'h2a, 32'hffff_0b01, 32'hffff_ffff},
             '{8'h00, 1'b1, 1'b1, 8'h63, 32'h6304_0b00, 32'hffff_ffff},
             '{8'h00, 1'b1, 1'b1, 8'h64, 32'hff04_0b00, 32'hffff_ffff}};
    repeat (5) @(posedge clk_sys);
    check(ev_ready, 32'h0);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd_check(`EVLOG_OFF_CTRL, 32'h0000_0000);
    rd_check(`EVLOG_OFF_PARAM, 32'h0000_0804);
    rd_check(`EVLOG_OFF_AGE, 32'h0000_ffff);
    rd_check(`EVLOG_OFF_STATUS, 32'h0000_1000);
    rd_check(8'h3c, 32'h0000_0000);
    bus(1'b1, `EVLOG_OFF_RD_INDEX, 32'h0000_0000);
    foreach (rows[r]) begin
      bus(1'b1, `EVLOG_OFF_CTRL, 32'h0000_0100);
      stamp <= {rows[r].offv, 8'h04, 40'h12_3456_789a, rows[r].fine, rows[r].hund};
      i_event_source.send({rows[r].kind, 3'h4, 32'hc0de_0000 + 32'(r)});
      bus(1'b0, `EVLOG_OFF_RD_HDR, 32'h0000_0000);
      check(rdata & rows[r].mask, rows[r].hdr);
      rd_check(`EVLOG_OFF_RD_DATA, 32'hc0de_0000 + 32'(r));
    end
    rd_check(`EVLOG_OFF_RD_SEC_LO, 32'h3456_789a);
    rd_check(`EVLOG_OFF_RD_SEC_HI, 32'h0000_0012);
    bus(1'b1, `EVLOG_OFF_CTRL, 32'h0000_0100);
    fill(16, 0);
    fork
      i_event_source.send(mk(16));
      begin
        repeat (8) @(posedge clk_sys);
        check(log_full, 32'h1);
        rd_check(`EVLOG_OFF_STATUS, 32'h0001_1010);
        bus(1'b1, `EVLOG_OFF_CTRL, 32'h0000_0100);
      end
    join
    rd_check(`EVLOG_OFF_STATUS, 32'h0000_1001);
    rd_check(`EVLOG_OFF_RD_DATA, 32'hc0de_0010);
    bus(1'b1, `EVLOG_OFF_CTRL, 32'h0000_0101);
    fill(17, 0);
    rd_check(`EVLOG_OFF_STATUS, 32'h0002_100d);
    rd_check(`EVLOG_OFF_RD_DATA, 32'hc0de_0004);
    bus(1'b1, `EVLOG_OFF_PARAM, 32'h0001_0832);
    fill(4, 17);
    rd_check(`EVLOG_OFF_STATUS, 32'h0002_1009);
    bus(1'b1, `EVLOG_OFF_CTRL, 32'h0000_0102);
    bus(1'b1, `EVLOG_OFF_PARAM, 32'h0000_0804);
    bus(1'b1, `EVLOG_OFF_AGE, 32'h0000_0028);
    bus(1'b1, `EVLOG_OFF_CTRL, 32'h0000_0003);
    rd_check(`EVLOG_OFF_CTRL, 32'h0000_0002);
    virt_valid <= 1'b1;
    virt_data  <= mk(32'h99);
    do @(posedge clk_sys); while (virt_ready !== 1'b1);
    virt_valid <= 1'b0;
    virt_data  <= ~mk(32'h99);
    fill(7, 32'h20);
    rd_check(`EVLOG_OFF_RD_DATA, 32'hc0de_0099);
    repeat (60) @(posedge clk_sys);
    rd_check(`EVLOG_OFF_STATUS, 32'h0004_1008);
    i_event_source.send(mk(32'h27));
    repeat (10) @(posedge clk_sys);
    rd_check(`EVLOG_OFF_STATUS, 32'h0004_1005);
    rd_check(`EVLOG_OFF_RD_DATA, 32'hc0de_0023);
    bus(1'b1, `EVLOG_OFF_RECEIVER, 32'h0000_005a);
    check(receiver_eid, 32'h5a);
    rd_check(`EVLOG_OFF_RECEIVER, 32'h0000_005a);
    ce <= 1'b0;
    @(posedge clk_sys);
    rdata = {30'h0, virt_ready, ev_ready};
    repeat (3) @(posedge clk_sys);
    check({30'h0, virt_ready, ev_ready}, rdata); // Intake flags frozen
    ce    <= 1'b1;
    rst_n <= 1'b0;
    @(posedge clk_sys);
    check(receiver_eid, 32'h0);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd_check(`EVLOG_OFF_STATUS, 32'h0000_1000);
    tally_and_finish();
  end
endmodule // event_log_store_with_clearing_bench
